// >>> line_a_pkg.sv
// Constants, types and field layout for the channel A line control block
package line_a_pkg;

	// Control register location and reset value
	localparam logic [7:0] CTRL_ADDR  = 8'h06;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Bit positions inside the control register
	localparam int SPEED_LSB   = 6;
	localparam int SETUP_BIT   = 5;
	localparam int WAKE_BIT    = 4;
	localparam int TXCLR_BIT   = 3;
	localparam int RXCLR_BIT   = 2;
	localparam int ALLOW_BIT   = 1;
	localparam int GO_BIT      = 0;

	// Remote line rate codes
	localparam logic [1:0] SPEED_FAIL = 2'h0;
	localparam logic [1:0] SPEED_COM1 = 2'h1;
	localparam logic [1:0] SPEED_COM2 = 2'h2;
	localparam logic [1:0] SPEED_COM3 = 2'h3;

	// Timing: clock rate and line times
	localparam int CLK_MHZ    = 100;
	localparam int WAKE_US    = 80;
	localparam int LISTEN_US  = 500;
	localparam int WAKE_CYC   = WAKE_US * CLK_MHZ;
	localparam int LISTEN_CYC = LISTEN_US * CLK_MHZ;

	// Control register fields, MSB first
	typedef struct packed {
		logic [1:0] speed;
		logic       setup;
		logic       wake;
		logic       tx_clr;
		logic       rx_clr;
		logic       tick_allow;
		logic       msg_go;
	} line_ctrl_t;

	// Host serial port request after framing
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage

// >>> line_a_link_control.sv
// Channel A line control: setup sequence, wake-up, queues, cycle timer
`timescale 1ns/1ps
module line_a_link_control #(
	parameter int WAKE_CYCLES   = line_a_pkg::WAKE_CYC,
	parameter int LISTEN_CYCLES = line_a_pkg::LISTEN_CYC,
	parameter int PERIOD_W      = 16,
	parameter int CT_W          = 8
) (
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire line_a_pkg::reg_req_t reg_req,
	output logic [7:0]                reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 frame_engine_on_a,
	output logic                      line_tx_mode,
	output logic                      line_wake_drive,
	output logic                      current_boost,
	output logic                      probe_start,
	output logic [1:0]                probe_rate,
	input  wire logic                 probe_reply,
	input  wire logic [CT_W-1:0]      remote_cycle_time,
	output logic [CT_W-1:0]           device_cycle_time_a,
	output logic                      wake_done_irq,
	output logic                      tx_queue_flush,
	output logic                      rx_queue_flush,
	input  wire logic                 tx_queue_empty,
	input  wire logic [7:0]           tx_queue_data,
	output logic                      tx_queue_pop,
	input  wire logic                 uart_busy,
	output logic                      uart_load,
	output logic [7:0]                uart_data,
	input  wire logic [PERIOD_W-1:0]  cycle_period,
	input  wire logic                 trigger_cmd,
	output logic                      timer_running,
	output logic                      cycle_tick
);
	import line_a_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WAKE, ST_PROBE, ST_LISTEN, ST_SEND
	} state_t;
	localparam int WC_W = $clog2(WAKE_CYCLES + 1);
	localparam int LC_W = $clog2(LISTEN_CYCLES + 1);
	state_t          state_ff;
	line_ctrl_t      ctrl_ff;
	logic            auto_ff;
	logic [1:0]      rate_ff;
	logic [WC_W-1:0] wake_cnt_ff;
	logic [LC_W-1:0] listen_cnt_ff;
	logic [PERIOD_W-1:0] tick_cnt_ff;
	logic [7:0]      rdata_ff;
	logic            rvalid_ff;
	logic            irq_ff;
	logic            run_ff;
	logic            tick_ff;
	logic            load_ff;
	logic [7:0]      udata_ff;
	logic [CT_W-1:0] ct_ff;
	logic            probe_ff;
	line_ctrl_t      wr_val;
	logic            wr_hit;
	logic            wake_end;
	logic            listen_end;
	logic            send_done;
	logic            ok_evt;
	logic            fail_evt;
	assign wr_hit = reg_req.wr && (reg_req.addr == CTRL_ADDR);
	assign wr_val = line_ctrl_t'(reg_req.wdata);
	assign wake_end = (state_ff == ST_WAKE)
		&& (wake_cnt_ff == WC_W'(WAKE_CYCLES - 1));
	assign listen_end = (state_ff == ST_LISTEN)
		&& (listen_cnt_ff == LC_W'(LISTEN_CYCLES - 1));
	assign send_done = (state_ff == ST_SEND) && tx_queue_empty
		&& !uart_busy && !load_ff;
	assign ok_evt = (state_ff == ST_LISTEN) && probe_reply;
	assign fail_evt = listen_end && !probe_reply
		&& (rate_ff == SPEED_COM1);
	////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_ff <= ST_IDLE;
			auto_ff  <= 1'b0;
			rate_ff  <= SPEED_COM3;
			probe_ff <= 1'b0;
		end else begin
			probe_ff <= (state_ff == ST_PROBE);
			case (state_ff)
				ST_IDLE: begin
					if (ctrl_ff.setup && frame_engine_on_a) begin
						state_ff <= ST_WAKE;
						auto_ff  <= 1'b1;
						rate_ff  <= SPEED_COM3;
					end else if (ctrl_ff.wake) begin
						state_ff <= ST_WAKE;
						auto_ff  <= 1'b0;
					end else if (ctrl_ff.msg_go) begin
						state_ff <= ST_SEND;
					end
				end
				ST_WAKE: begin
					if (wake_end) begin
						state_ff <= auto_ff ? ST_PROBE : ST_IDLE;
					end
				end
				ST_PROBE: begin
					state_ff <= ST_LISTEN;
				end
				ST_LISTEN: begin
					if (ok_evt || fail_evt) begin
						state_ff <= ST_IDLE;
						auto_ff  <= 1'b0;
					end else if (listen_end) begin
						// Fall back to the next slower rate
						rate_ff  <= rate_ff - 2'h1;
						state_ff <= ST_PROBE;
					end
				end
				ST_SEND: begin
					if (send_done) begin
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (!srst && state_ff == ST_WAKE && !wake_end) begin
			wake_cnt_ff <= wake_cnt_ff + WC_W'(1);
		end else begin
			wake_cnt_ff <= '0;
		end
	end
	always_ff @(posedge mclk) begin
		if (!srst && state_ff == ST_LISTEN && !listen_end) begin
			listen_cnt_ff <= listen_cnt_ff + LC_W'(1);
		end else begin
			listen_cnt_ff <= '0;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Control register; a host set wins over a hardware clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_ff <= line_ctrl_t'(CTRL_RESET);
		end else begin
			if (ok_evt) begin
				ctrl_ff.speed <= rate_ff;
			end else if (fail_evt) begin
				ctrl_ff.speed <= SPEED_FAIL;
			end else if (wr_hit) begin
				ctrl_ff.speed <= wr_val.speed;
			end
			if (wr_hit && wr_val.setup) begin
				ctrl_ff.setup <= 1'b1;
			end else if (ok_evt || fail_evt) begin
				ctrl_ff.setup <= 1'b0;
			end else if (wr_hit) begin
				ctrl_ff.setup <= 1'b0;
			end
			if (wr_hit && wr_val.wake) begin
				ctrl_ff.wake <= 1'b1;
			end else if (wake_end && !auto_ff) begin
				ctrl_ff.wake <= 1'b0;
			end else if (wr_hit) begin
				ctrl_ff.wake <= 1'b0;
			end
			// One-shot queue clears
			ctrl_ff.tx_clr <= wr_hit && wr_val.tx_clr;
			ctrl_ff.rx_clr <= wr_hit && wr_val.rx_clr;
			if (wr_hit) begin
				ctrl_ff.tick_allow <= wr_val.tick_allow;
			end
			if (wr_hit && wr_val.msg_go) begin
				ctrl_ff.msg_go <= 1'b1;
			end else if (send_done || wr_hit) begin
				ctrl_ff.msg_go <= 1'b0;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_ff <= 1'b0;
			ct_ff  <= '0;
		end else begin
			irq_ff <= ok_evt || fail_evt;
			if (ok_evt) begin
				ct_ff <= remote_cycle_time;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= reg_req.rd;
			rdata_ff  <= (reg_req.addr == CTRL_ADDR) ? 8'(ctrl_ff) : 8'h00;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Master message transmit
	assign tx_queue_pop = (state_ff == ST_SEND) && !tx_queue_empty
		&& !uart_busy && !load_ff;
	always_ff @(posedge mclk) begin
		if (srst) begin
			load_ff  <= 1'b0;
			udata_ff <= 8'h00;
		end else begin
			load_ff <= tx_queue_pop;
			if (tx_queue_pop) begin
				udata_ff <= tx_queue_data;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Cycle timer
	always_ff @(posedge mclk) begin
		if (srst) begin
			run_ff      <= 1'b0;
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (wr_hit && !wr_val.tick_allow) begin
				run_ff      <= 1'b0;
				tick_cnt_ff <= '0;
			end else if (!run_ff) begin
				tick_cnt_ff <= '0;
				if (ctrl_ff.tick_allow && ((wr_hit && wr_val.msg_go)
					|| trigger_cmd)) begin
					run_ff <= 1'b1;
				end
			end else if (tick_cnt_ff >= cycle_period - PERIOD_W'(1)) begin
				tick_cnt_ff <= '0;
				tick_ff     <= 1'b1;
			end else begin
				tick_cnt_ff <= tick_cnt_ff + PERIOD_W'(1);
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata           = rdata_ff;
	assign reg_rvalid          = rvalid_ff;
	assign line_wake_drive     = (state_ff == ST_WAKE);
	assign current_boost       = (state_ff == ST_WAKE) && auto_ff;
	assign line_tx_mode        = (state_ff == ST_WAKE)
		|| (state_ff == ST_PROBE) || (state_ff == ST_SEND);
	assign probe_start         = probe_ff;
	assign probe_rate          = rate_ff;
	assign device_cycle_time_a = ct_ff;
	assign wake_done_irq       = irq_ff;
	assign tx_queue_flush      = ctrl_ff.tx_clr;
	assign rx_queue_flush      = ctrl_ff.rx_clr;
	assign uart_load           = load_ff;
	assign uart_data           = udata_ff;
	assign timer_running       = run_ff;
	assign cycle_tick          = tick_ff;
	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_setup_req;
		state_ff == ST_IDLE && ctrl_ff.setup && frame_engine_on_a;
	endsequence
	sequence s_wake_out;
		line_wake_drive && line_tx_mode;
	endsequence
	property p_setup_wakes;
		s_setup_req |=> s_wake_out ##0 current_boost;
	endproperty
	a_setup_wakes: assert property (p_setup_wakes)
		else $error("setup request did not start a boosted wake pulse");
	// A host set of the setup bit in the same cycle wins over the clear
	property p_ok_done;
		ok_evt && !(wr_hit && wr_val.setup) |=> wake_done_irq
			&& ctrl_ff.speed == $past(rate_ff) && !ctrl_ff.setup;
	endproperty
	a_ok_done: assert property (p_ok_done)
		else $error("setup success not reported correctly");
	property p_fail_done;
		fail_evt |=> wake_done_irq && ctrl_ff.speed == SPEED_FAIL;
	endproperty
	a_fail_done: assert property (p_fail_done)
		else $error("setup failure not reported correctly");
	property p_manual_wake;
		state_ff == ST_IDLE && ctrl_ff.wake && !ctrl_ff.setup
			|=> s_wake_out ##0 !current_boost;
	endproperty
	a_manual_wake: assert property (p_manual_wake)
		else $error("manual wake pulse wrong");
	property p_wake_clear;
		wake_end && !auto_ff && !(wr_hit && wr_val.wake)
			|=> !ctrl_ff.wake && !line_tx_mode;
	endproperty
	a_wake_clear: assert property (p_wake_clear)
		else $error("wake bit not cleared after pulse");
	property p_flush;
		wr_hit && wr_val.tx_clr |=> tx_queue_flush ##1 !ctrl_ff.tx_clr;
	endproperty
	a_flush: assert property (p_flush)
		else $error("tx queue clear not one-shot");
	property p_arm_only;
		!run_ff && !trigger_cmd && !(wr_hit && wr_val.msg_go) |=> !run_ff;
	endproperty
	a_arm_only: assert property (p_arm_only)
		else $error("cycle timer started without a start event");
	property p_stop;
		wr_hit && !wr_val.tick_allow |=> !run_ff;
	endproperty
	a_stop: assert property (p_stop)
		else $error("cycle timer not stopped");
	property p_turnaround;
		send_done |=> !line_tx_mode && !(ctrl_ff.msg_go && !$past(wr_hit));
	endproperty
	a_turnaround: assert property (p_turnaround)
		else $error("transceiver not returned to receive");
endmodule

// >>> remote_sensor_model.sv
// Remote sensor model: probe replies, transmit queue, line UART
`timescale 1ns/1ps
module remote_sensor_model (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic [1:0] answer_rate,
	input  wire logic       probe_start,
	input  wire logic [1:0] probe_rate,
	input  wire logic       tx_queue_pop,
	input  wire logic       tx_queue_flush,
	input  wire logic       uart_load,
	input  wire logic [2:0] fill_n,
	input  wire logic       fill_go,
	output logic            probe_reply,
	output logic [7:0]      remote_cycle_time,
	output logic            tx_queue_empty,
	output logic [7:0]      tx_queue_data,
	output logic            uart_busy
);
	logic [2:0] reply_ff;
	logic [2:0] cnt_ff;
	logic [2:0] busy_ff;

	////////////////////////////////////////////////////////////////////////
	// Answers three cycles after a probe at its own rate; 0 never answers
	always_ff @(posedge mclk) begin
		if (srst)
			reply_ff <= 3'h0;
		else
			reply_ff <= {reply_ff[1:0], probe_start && answer_rate != 2'h0
				&& probe_rate == answer_rate};
	end
	assign probe_reply       = reply_ff[2];
	assign remote_cycle_time = probe_reply ? 8'h2a : 8'hd5;

	////////////////////////////////////////////////////////////////////////
	// Queue depth only; head byte shows its position
	always_ff @(posedge mclk) begin
		if (srst || tx_queue_flush)
			cnt_ff <= 3'h0;
		else if (fill_go)
			cnt_ff <= fill_n;
		else if (tx_queue_pop && cnt_ff != 3'h0)
			cnt_ff <= cnt_ff - 3'h1;
	end
	assign tx_queue_empty = cnt_ff == 3'h0;
	assign tx_queue_data  = tx_queue_empty ? 8'hff : {5'h14, cnt_ff};

	////////////////////////////////////////////////////////////////////////
	// UART busy for four cycles after each load
	always_ff @(posedge mclk) begin
		if (srst)
			busy_ff <= 3'h0;
		else if (uart_load)
			busy_ff <= 3'h4;
		else if (busy_ff != 3'h0)
			busy_ff <= busy_ff - 3'h1;
	end
	assign uart_busy = busy_ff != 3'h0;
endmodule

// >>> line_a_link_control_tb_top.sv
// Testbench for the channel A line control block
`timescale 1ns/1ps
module line_a_link_control_tb_top;
	import line_a_pkg::*;
	localparam int WC = 20;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	reg_req_t    req = '0;
	logic        fe_on = 1'b1;
	logic [1:0]  ans = 2'h0;
	logic [2:0]  fill_n = 3'h0;
	logic        fill_go = 1'b0;
	logic [15:0] cycle_period = 16'h0005;
	logic        trigger_cmd = 1'b0;
	logic [7:0]  rdata, uart_data, rct, dct, q_data;
	logic [1:0]  p_rate;
	logic        rvalid, tx_mode, wake_drv, boost, p_start, p_reply, irq;
	logic        tx_fl, rx_fl, q_empty, q_pop, u_busy, u_load, running, tick;
	int          n_fail = 0, checked = 0, n_cyc = 0, ticks = 0, n_load = 0;

	always #5 mclk = ~mclk;

	line_a_link_control #(.WAKE_CYCLES(WC), .LISTEN_CYCLES(40))
	i_line_a_link_control (.mclk(mclk), .srst(srst), .reg_req(req),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .frame_engine_on_a(fe_on),
		.line_tx_mode(tx_mode), .line_wake_drive(wake_drv),
		.current_boost(boost), .probe_start(p_start), .probe_rate(p_rate),
		.probe_reply(p_reply), .remote_cycle_time(rct),
		.device_cycle_time_a(dct), .wake_done_irq(irq),
		.tx_queue_flush(tx_fl), .rx_queue_flush(rx_fl),
		.tx_queue_empty(q_empty), .tx_queue_data(q_data),
		.tx_queue_pop(q_pop), .uart_busy(u_busy), .uart_load(u_load),
		.uart_data(uart_data), .cycle_period(cycle_period),
		.trigger_cmd(trigger_cmd), .timer_running(running),
		.cycle_tick(tick));

	remote_sensor_model i_remote_sensor_model (.mclk(mclk), .srst(srst),
		.answer_rate(ans), .probe_start(p_start), .probe_rate(p_rate),
		.tx_queue_pop(q_pop), .tx_queue_flush(tx_fl), .uart_load(u_load),
		.fill_n(fill_n), .fill_go(fill_go), .probe_reply(p_reply),
		.remote_cycle_time(rct), .tx_queue_empty(q_empty),
		.tx_queue_data(q_data), .uart_busy(u_busy));

	task automatic end_sim();
		$display("checks %0d, errors %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] d);
		cyc(1);
		req = '{1'b1, 1'b0, CTRL_ADDR, d};
		cyc(1);
		req = '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		req = '{1'b0, 1'b1, a, 8'h00};
		cyc(1);
		req = '0;
		chk(rvalid === 1'b1 && rdata === e, "read value");
	endtask

	task automatic fill(input logic [2:0] n);
		fill_n = n;
		fill_go = 1'b1;
		cyc(1);
		fill_go = 1'b0;
	endtask

	task automatic run_setup(input logic [1:0] r);
		int i;
		ans = r;
		wr(8'h20);
		cyc(4);
		chk(wake_drv === 1'b1 && boost === 1'b1, "no boosted wake");
		i = 0;
		while (irq !== 1'b1 && i < 400) begin
			cyc(1);
			i++;
		end
		chk(irq === 1'b1, "no setup done");
		rd(CTRL_ADDR, {r, 6'h00});
		if (r != 2'h0)
			chk(dct === 8'h2a, "cycle time");
	endtask

	// Cycle counter, tick and load counts, hang guard
	always @(posedge mclk) begin
		n_cyc++;
		if (tick === 1'b1)
			ticks++;
		if (u_load === 1'b1) begin
			chk(uart_data === {5'h14, 3'(3 - n_load)}, "uart byte");
			n_load++;
		end
		if (n_cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end

	initial begin
		int i;
		repeat (8) @(posedge mclk);
		#1 srst = 1'b0;
		rd(CTRL_ADDR, CTRL_RESET);
		rd(8'h07, 8'h00);
		////////////////////////////////////////////////////////////////////
		fill(3'h2);
		wr(8'h08);
		chk(tx_fl === 1'b1 && rx_fl === 1'b0, "tx clear");
		cyc(1);
		chk(q_empty === 1'b1 && tx_fl === 1'b0, "tx one-shot");
		wr(8'h04);
		chk(rx_fl === 1'b1 && tx_fl === 1'b0, "rx clear");
		rd(CTRL_ADDR, 8'h00);
		////////////////////////////////////////////////////////////////////
		// Setup request waits while the framer is off
		fe_on = 1'b0;
		wr(8'h20);
		cyc(5);
		chk(wake_drv === 1'b0, "setup ran with framer off");
		rd(CTRL_ADDR, 8'h20);
		fe_on = 1'b1;
		for (int k = 3; k >= 0; k--)
			run_setup(2'(k));
		////////////////////////////////////////////////////////////////////
		// Host-managed wake pulse, no setup running
		wr(8'h10);
		cyc(2);
		chk(wake_drv === 1'b1 && boost === 1'b0, "wake pulse");
		cyc(WC + 2);
		chk(wake_drv === 1'b0 && tx_mode === 1'b0, "wake end");
		rd(CTRL_ADDR, 8'h00);
		////////////////////////////////////////////////////////////////////
		wr(8'h02);
		cyc(10);
		chk(running === 1'b0, "armed only");
		trigger_cmd = 1'b1;
		cyc(1);
		trigger_cmd = 1'b0;
		chk(running === 1'b1, "trigger start");
		ticks = 0;
		cyc(20);
		chk(ticks >= 3 && ticks <= 5, "tick count");
		wr(8'h00);
		chk(running === 1'b0, "stop");
		////////////////////////////////////////////////////////////////////
		fill(3'h3);
		wr(8'h02);
		n_load = 0;
		wr(8'h03);
		cyc(2);
		chk(tx_mode === 1'b1 && running === 1'b1, "send start");
		i = 0;
		while (tx_mode !== 1'b0 && i < 200) begin
			cyc(1);
			i++;
		end
		chk(n_load == 3 && q_empty === 1'b1, "send bytes");
		rd(CTRL_ADDR, 8'h02);
		wr(8'h00);
		end_sim();
	end
endmodule
